/* design/arsr_pkg.sv */
// Package of constants and types for the converter result and scan block.
package arsr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_STATUS_CTRL = 8'h57;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h58;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h59;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h5A;
  localparam logic [7:0] OFF_SCAN_CH1 = 8'h5B;
  localparam logic [7:0] OFF_SCAN_CH2 = 8'h5C;
  localparam logic [7:0] OFF_SCAN_CH3 = 8'h5D;
  localparam logic [7:0] OFF_SCAN_CTRL = 8'h5E;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h60;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h61;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_DONE_FLAG = 7;
  localparam int POS_IRQ_EN = 6;
  localparam int POS_CONT = 5;
  localparam int POS_MODE_LO = 2;
  localparam int POS_SCAN_EN = 2;
  localparam int POS_COUNT_LO = 0;
  localparam int POS_EV_DONE = 0;
  localparam int POS_EV_LOST = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h1;
  localparam logic [1:0] RST_COUNT = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    JUST_TRUNC = 2'h0,
    JUST_RIGHT = 2'h1,
    JUST_LEFT = 2'h2,
    JUST_SIGNED = 2'h3
  } arsr_just_t;

  typedef enum logic [2:0] {
    ST_OPEN = 3'h1,
    ST_HELD = 3'h2,
    ST_SKIP = 3'h4
  } arsr_lock_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } arsr_bus_t;

  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic scanning;
    logic [9:0] value;
  } arsr_conv_t;

endpackage : arsr_pkg

/* design/arsr_regs.sv */
// Result formatting, read interlock and scan control registers.
`timescale 1ns/100ps
module arsr_regs #(
  parameter int RES_WIDTH = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire arsr_pkg::arsr_bus_t bus,
  output logic [7:0] rdata,
  // Conversion core
  input wire arsr_pkg::arsr_conv_t conv,
  output logic scan_enable,
  output logic [1:0] scan_count,
  output logic continuous_convert,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (RES_WIDTH != 10) begin : g_bad_width
    $error("Only a 10-bit result is supported.");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] high_reg, high_next;
  logic [7:0] low_reg, low_next;
  logic [7:0] scan_res_reg [1:3];
  logic [7:0] scan_res_next [1:3];
  arsr_pkg::arsr_just_t mode_reg, mode_next;
  arsr_pkg::arsr_lock_t lock_reg, lock_next;
  logic irq_en_reg, irq_en_next;
  logic cont_reg, cont_next;
  logic done_reg, done_next;
  logic req_reg, req_next;
  logic scan_en_reg, scan_en_next;
  logic [1:0] count_reg, count_next;
  logic [1:0] ev_stat_reg, ev_stat_next;
  logic [1:0] ev_mask_reg, ev_mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function automatic logic hit(input arsr_pkg::arsr_bus_t b,
                               input logic [7:0] off);
    hit = b.addr == off;
  endfunction : hit

  logic rd_high, rd_low, wr_sc, result0, lost;
  logic [7:0] fmt_high, fmt_low;

  always_comb begin
    rd_high = bus.rd && hit(bus, arsr_pkg::OFF_RESULT_HIGH);
    rd_low = bus.rd && hit(bus, arsr_pkg::OFF_RESULT_LOW);
    wr_sc = bus.wr && hit(bus, arsr_pkg::OFF_STATUS_CTRL);
    // Channel 0 of a scan, or any single conversion, lands in register 0.
    result0 = conv.valid && (!conv.scanning || conv.channel == 2'h0);
    case (mode_reg)
      arsr_pkg::JUST_TRUNC: begin
        fmt_high = 8'h00;
        fmt_low = conv.value[9:2];
      end
      arsr_pkg::JUST_RIGHT: begin
        fmt_high = {6'h00, conv.value[9:8]};
        fmt_low = conv.value[7:0];
      end
      arsr_pkg::JUST_LEFT: begin
        fmt_high = conv.value[9:2];
        fmt_low = {conv.value[1:0], 6'h00};
      end
      default: begin
        fmt_high = {~conv.value[9], conv.value[8:2]};
        fmt_low = {conv.value[1:0], 6'h00};
      end
    endcase
  end

  // ****************************************************************
  // Result pair and interlock
  // ****************************************************************
  always_comb begin
    high_next = high_reg;
    low_next = low_reg;
    lock_next = lock_reg;
    lost = 1'b0;
    case (lock_reg)
      arsr_pkg::ST_OPEN: begin
        if (rd_high && mode_reg != arsr_pkg::JUST_TRUNC) begin
          lock_next = arsr_pkg::ST_HELD;
        end
      end
      arsr_pkg::ST_HELD: begin
        if (rd_low) begin
          lock_next = arsr_pkg::ST_OPEN;
        end
      end
      default: begin
        lock_next = arsr_pkg::ST_OPEN;
      end
    endcase
    if (result0) begin
      // Truncated mode never holds, so a pending lock is ignored there. A
      // high-byte read in the same cycle pins the pair already: taking the
      // result then would pair an old high byte with a new low byte.
      if (mode_reg != arsr_pkg::JUST_TRUNC &&
          ((lock_reg == arsr_pkg::ST_HELD && !rd_low) ||
           (lock_reg == arsr_pkg::ST_OPEN && rd_high))) begin
        lost = 1'b1;
      end else begin
        high_next = fmt_high;
        low_next = fmt_low;
      end
    end
  end

  // ****************************************************************
  // Scan result registers
  // ****************************************************************
  for (genvar i = 1; i <= 3; i++) begin : g_scan
    always_comb begin
      scan_res_next[i] = scan_res_reg[i];
      if (conv.valid && conv.scanning && mode_reg == arsr_pkg::JUST_TRUNC &&
          conv.channel == 2'(i)) begin
        scan_res_next[i] = conv.value[9:2];
      end
    end
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        scan_res_reg[i] <= arsr_pkg::RST_BYTE;
      end else begin
        scan_res_reg[i] <= scan_res_next[i];
      end
    end
  end

  // ****************************************************************
  // Control, flags and read data
  // ****************************************************************
  always_comb begin
    mode_next = mode_reg;
    irq_en_next = irq_en_reg;
    cont_next = cont_reg;
    scan_en_next = scan_en_reg;
    count_next = count_reg;
    ev_mask_next = ev_mask_reg;
    done_next = done_reg;
    req_next = req_reg;
    ev_stat_next = ev_stat_reg;
    if (wr_sc) begin
      irq_en_next = bus.wdata[arsr_pkg::POS_IRQ_EN];
      cont_next = bus.wdata[arsr_pkg::POS_CONT];
      req_next = 1'b0;
    end
    if (bus.wr && hit(bus, arsr_pkg::OFF_MODE_CTRL)) begin
      mode_next = arsr_pkg::arsr_just_t'(
        bus.wdata[arsr_pkg::POS_MODE_LO +: 2]);
    end
    if (bus.wr && hit(bus, arsr_pkg::OFF_SCAN_CTRL)) begin
      scan_en_next = bus.wdata[arsr_pkg::POS_SCAN_EN];
      count_next = bus.wdata[arsr_pkg::POS_COUNT_LO +: 2];
    end
    if (bus.wr && hit(bus, arsr_pkg::OFF_IRQ_MASK)) begin
      ev_mask_next = bus.wdata[1:0];
    end
    if (bus.wr && hit(bus, arsr_pkg::OFF_IRQ_STATUS)) begin
      ev_stat_next = ev_stat_reg & ~bus.wdata[1:0];
    end
    if (rd_high || rd_low) begin
      done_next = 1'b0;
      req_next = 1'b0;
    end
    // Setting follows clearing so a same-cycle event is never lost.
    if (conv.valid) begin
      done_next = done_next | ~irq_en_reg;
      req_next = req_next | irq_en_reg;
      ev_stat_next[arsr_pkg::POS_EV_DONE] = 1'b1;
    end
    if (lost) begin
      ev_stat_next[arsr_pkg::POS_EV_LOST] = 1'b1;
    end
    irq_next = req_next || |(ev_stat_next & ev_mask_next);
    rdata_next = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        arsr_pkg::OFF_STATUS_CTRL: begin
          rdata_next[arsr_pkg::POS_DONE_FLAG] = done_reg;
          rdata_next[arsr_pkg::POS_IRQ_EN] = irq_en_reg;
          rdata_next[arsr_pkg::POS_CONT] = cont_reg;
        end
        arsr_pkg::OFF_MODE_CTRL: begin
          rdata_next[arsr_pkg::POS_MODE_LO +: 2] = mode_reg;
        end
        arsr_pkg::OFF_RESULT_HIGH: rdata_next = high_reg;
        arsr_pkg::OFF_RESULT_LOW: rdata_next = low_reg;
        arsr_pkg::OFF_SCAN_CH1: rdata_next = scan_res_reg[1];
        arsr_pkg::OFF_SCAN_CH2: rdata_next = scan_res_reg[2];
        arsr_pkg::OFF_SCAN_CH3: rdata_next = scan_res_reg[3];
        arsr_pkg::OFF_SCAN_CTRL: begin
          rdata_next[arsr_pkg::POS_SCAN_EN] = scan_en_reg;
          rdata_next[arsr_pkg::POS_COUNT_LO +: 2] = count_reg;
        end
        arsr_pkg::OFF_IRQ_STATUS: rdata_next[1:0] = ev_stat_reg;
        arsr_pkg::OFF_IRQ_MASK: rdata_next[1:0] = ev_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      high_reg <= arsr_pkg::RST_BYTE;
      low_reg <= arsr_pkg::RST_BYTE;
      lock_reg <= arsr_pkg::ST_OPEN;
      mode_reg <= arsr_pkg::arsr_just_t'(arsr_pkg::RST_MODE);
      irq_en_reg <= 1'b0;
      cont_reg <= 1'b0;
      done_reg <= 1'b0;
      req_reg <= 1'b0;
      scan_en_reg <= 1'b0;
      count_reg <= arsr_pkg::RST_COUNT;
      ev_stat_reg <= 2'h0;
      ev_mask_reg <= 2'h0;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      high_reg <= high_next;
      low_reg <= low_next;
      lock_reg <= lock_next;
      mode_reg <= mode_next;
      irq_en_reg <= irq_en_next;
      cont_reg <= cont_next;
      done_reg <= done_next;
      req_reg <= req_next;
      scan_en_reg <= scan_en_next;
      count_reg <= count_next;
      ev_stat_reg <= ev_stat_next;
      ev_mask_reg <= ev_mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign scan_enable = scan_en_reg;
  assign scan_count = count_reg;
  assign continuous_convert = cont_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // All checks run on the one system clock and sleep through reset.
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // A high-byte read that pins the pair in a two-byte mode.
  sequence s_high_read;
    rd_high && mode_reg != arsr_pkg::JUST_TRUNC &&
      lock_reg == arsr_pkg::ST_OPEN;
  endsequence

  // A result for register 0 that finds the pair free.
  sequence s_open_result;
    result0 && lock_reg == arsr_pkg::ST_OPEN && !rd_high;
  endsequence

  // A result for register 0 that finds the pair pinned.
  sequence s_held_result;
    result0 && lock_reg == arsr_pkg::ST_HELD && !rd_low &&
      mode_reg != arsr_pkg::JUST_TRUNC;
  endsequence

  AST_TRUNC_HIGH_ZERO: assert property (
    result0 && mode_reg == arsr_pkg::JUST_TRUNC |=> high_reg == 8'h00)
    else $error("Truncated high byte not zero.");
  AST_TRUNC_OVERWRITE: assert property (
    result0 && mode_reg == arsr_pkg::JUST_TRUNC
    |=> low_reg == $past(conv.value[9:2]))
    else $error("Truncated low byte not updated.");
  AST_RIGHT_LAYOUT: assert property (
    s_open_result ##0 mode_reg == arsr_pkg::JUST_RIGHT
    |=> {high_reg, low_reg} == {6'h00, $past(conv.value)})
    else $error("Right layout wrong.");
  AST_LEFT_LAYOUT: assert property (
    s_open_result ##0 mode_reg == arsr_pkg::JUST_LEFT
    |=> {high_reg, low_reg} == {$past(conv.value), 6'h00})
    else $error("Left layout wrong.");
  AST_SIGNED_MSB: assert property (
    s_open_result ##0 mode_reg == arsr_pkg::JUST_SIGNED
    |=> {high_reg, low_reg} ==
        {~$past(conv.value[9]), $past(conv.value[8:0]), 6'h00})
    else $error("Signed layout wrong.");
  AST_HIGH_READ_LOCKS: assert property (
    s_high_read |=> lock_reg == arsr_pkg::ST_HELD)
    else $error("High read did not pin the pair.");
  AST_LOCK_HOLDS: assert property (
    s_held_result |=> $stable(low_reg) && $stable(high_reg))
    else $error("Held low byte changed.");
  AST_READ_RESULT_DROP: assert property (
    s_high_read ##0 result0 |=> $stable(low_reg) && $stable(high_reg))
    else $error("Result taken in the cycle of a high read.");
  AST_SCAN_STORE: assert property (
    conv.valid && conv.scanning && conv.channel == 2'h1 &&
    mode_reg == arsr_pkg::JUST_TRUNC
    |=> scan_res_reg[1] == $past(conv.value[9:2]))
    else $error("Scan channel 1 not stored.");
  AST_DONE_FLAG: assert property (
    conv.valid && !irq_en_reg
    |=> done_reg ##1 (done_reg || $past(rd_high || rd_low)))
    else $error("Done flag not held.");
  AST_DONE_SILENT: assert property (
    conv.valid && irq_en_reg && !done_reg |=> !done_reg)
    else $error("Done flag set with the interrupt enabled.");
  AST_IRQ_RAISE: assert property (
    conv.valid && irq_en_reg |=> req_reg && irq_reg)
    else $error("Request not raised.");
  AST_IRQ_DROP: assert property (
    wr_sc && !conv.valid && ev_mask_reg == 2'h0 |=> !req_reg && !irq_reg)
    else $error("Request not withdrawn.");

endmodule : arsr_regs

/* bench/arsr_core_model.sv */
// Behavioural model of the conversion core that feeds the result block.
`timescale 1ns/100ps
module arsr_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Request from the bench
  input wire logic go,
  input wire logic [9:0] base,
  // Scan setup from the block
  input wire logic scan_enable,
  input wire logic [1:0] scan_count,
  // Results to the block
  output arsr_pkg::arsr_conv_t conv,
  output logic busy
);
  logic [1:0] ch_reg;
  logic [1:0] last_reg;
  logic [1:0] gap_reg;

  // The value bus toggles between results so a stale value never matches.
  always_ff @(posedge clk_sys) begin
    conv.valid <= 1'b0;
    conv.value <= ~conv.value;
    if (reset) begin
      conv <= '0;
      busy <= 1'b0;
      ch_reg <= 2'h0;
      last_reg <= 2'h0;
      gap_reg <= 2'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      ch_reg <= 2'h0;
      gap_reg <= 2'h3;
      last_reg <= scan_enable ? scan_count : 2'h0;
      conv.scanning <= scan_enable;
    end else if (busy) begin
      gap_reg <= gap_reg - 2'h1;
      if (gap_reg == 2'h0) begin
        conv.valid <= 1'b1;
        conv.channel <= ch_reg;
        conv.value <= base + 10'(ch_reg) * 10'h25;
        ch_reg <= ch_reg + 2'h1;
        gap_reg <= 2'h3;
        busy <= (ch_reg != last_reg);
      end
    end
  end
endmodule : arsr_core_model

/* bench/arsr_regs_bench.sv */
// Self-checking bench for the converter result and scan registers.
`timescale 1ns/100ps
module arsr_regs_bench;
  logic clk_sys, reset, go, irq, scan_enable, continuous_convert, busy;
  logic [1:0] scan_count;
  logic [7:0] rdata;
  logic [9:0] base, v, w;
  logic [15:0] f;
  arsr_pkg::arsr_bus_t bus;
  arsr_pkg::arsr_conv_t conv;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  int failures = 0;
  int checks_done = 0;

  arsr_regs DUT (.clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata),
    .conv(conv), .scan_enable(scan_enable), .scan_count(scan_count),
    .continuous_convert(continuous_convert), .irq(irq));
  arsr_core_model core (.clk_sys(clk_sys), .reset(reset), .go(go),
    .base(base), .scan_enable(scan_enable), .scan_count(scan_count),
    .conv(conv), .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************
  // Checking
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_sys) begin
    if (rd_pend && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
    rd_pend <= bus.rd;
  end

  // ****************
  // Bus and core
  // ****************
  task automatic acc(input logic wr, rd, input logic [7:0] a, d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: wr, rd: rd};
  endtask : acc

  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic wait_cyc(input int k);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  task automatic convert(input logic [9:0] x);
    int n;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    base <= x;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 60);
    if (n >= 60) begin
      failures++;
      test_done();
    end
  endtask : convert

  function automatic logic [15:0] fmt(input logic [1:0] m,
                                      input logic [9:0] x);
    case (m)
      2'h0: fmt = {8'h00, x[9:2]};
      2'h1: fmt = {6'h00, x[9:8], x[7:0]};
      2'h2: fmt = {x[9:2], x[1:0], 6'h00};
      default: fmt = {~x[9], x[8:2], x[1:0], 6'h00};
    endcase
  endfunction : fmt

  // ****************
  // Scenarios
  // ****************
  initial begin
    bus = '0;
    go = 1'b0;
    base = 10'h000;
    reset = 1'b1;
    void'($urandom(32'hEE0F3656));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    acc(1'b1, 1'b0, arsr_pkg::OFF_RESULT_HIGH, 8'hFF);
    rd(arsr_pkg::OFF_RESULT_HIGH, 8'h00);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'h00);
    rd(arsr_pkg::OFF_SCAN_CTRL, 8'h00);
    rd(arsr_pkg::OFF_MODE_CTRL, 8'h04);
    rd(8'h70, 8'h00);
    for (int m = 0; m < 4; m++) begin
      v = 10'($urandom);
      acc(1'b1, 1'b0, arsr_pkg::OFF_MODE_CTRL, {4'h0, 2'(m), 2'h0});
      convert(v);
      f = fmt(2'(m), v);
      rd(arsr_pkg::OFF_RESULT_HIGH, f[15:8]);
      rd(arsr_pkg::OFF_RESULT_LOW, f[7:0]);
    end
    // A result that arrives while the low byte is frozen must vanish.
    acc(1'b1, 1'b0, arsr_pkg::OFF_MODE_CTRL, 8'h04);
    convert(10'h2A5);
    rd(arsr_pkg::OFF_RESULT_HIGH, 8'h02);
    convert(10'h15A);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'hA5);
    rd(arsr_pkg::OFF_RESULT_HIGH, 8'h02);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'hA5);
    convert(10'h15A);
    rd(arsr_pkg::OFF_STATUS_CTRL, 8'h80);
    rd(arsr_pkg::OFF_RESULT_HIGH, 8'h01);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'h5A);
    rd(arsr_pkg::OFF_STATUS_CTRL, 8'h00);
    acc(1'b1, 1'b0, arsr_pkg::OFF_MODE_CTRL, 8'h00);
    convert(10'h3FC);
    rd(arsr_pkg::OFF_RESULT_HIGH, 8'h00);
    convert(10'h104);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'h41);
    // Continuous conversion is written back off before scanning is used.
    acc(1'b1, 1'b0, arsr_pkg::OFF_STATUS_CTRL, 8'h40);
    convert(10'h000);
    wait_cyc(3);
    chk({7'h00, irq}, 8'h01);
    acc(1'b1, 1'b0, arsr_pkg::OFF_STATUS_CTRL, 8'h40);
    wait_cyc(3);
    chk({7'h00, irq}, 8'h00);
    convert(10'h000);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'h00);
    wait_cyc(3);
    chk({7'h00, irq}, 8'h00);
    acc(1'b1, 1'b0, arsr_pkg::OFF_STATUS_CTRL, 8'h20);
    wait_cyc(1);
    chk({7'h00, continuous_convert}, 8'h01);
    rd(arsr_pkg::OFF_STATUS_CTRL, 8'h20);
    acc(1'b1, 1'b0, arsr_pkg::OFF_STATUS_CTRL, 8'h00);
    acc(1'b1, 1'b0, arsr_pkg::OFF_IRQ_STATUS, 8'h03);
    acc(1'b1, 1'b0, arsr_pkg::OFF_IRQ_MASK, 8'h01);
    convert(10'h000);
    wait_cyc(3);
    chk({7'h00, irq}, 8'h01);
    acc(1'b1, 1'b0, arsr_pkg::OFF_IRQ_STATUS, 8'h01);
    acc(1'b1, 1'b0, arsr_pkg::OFF_IRQ_MASK, 8'h00);
    convert(10'h000);
    wait_cyc(3);
    chk({7'h00, irq}, 8'h00);
    rd(arsr_pkg::OFF_IRQ_STATUS, 8'h01);
    acc(1'b1, 1'b0, arsr_pkg::OFF_SCAN_CTRL, 8'h07);
    rd(arsr_pkg::OFF_SCAN_CTRL, 8'h07);
    v = 10'($urandom);
    convert(v);
    chk({4'h0, continuous_convert, scan_enable, scan_count}, 8'h07);
    for (int n = 0; n < 4; n++) begin
      w = v + 10'(n) * 10'h25;
      rd(n == 0 ? arsr_pkg::OFF_RESULT_LOW : 8'(8'h5A + n), w[9:2]);
    end
    wait_cyc(1);
    // A second reset in mid-run must clear the scan set-up and the low result byte.
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(arsr_pkg::OFF_SCAN_CTRL, 8'h00);
    rd(arsr_pkg::OFF_MODE_CTRL, 8'h04);
    rd(arsr_pkg::OFF_RESULT_LOW, 8'h00);
    wait_cyc(3);
    if (exp_q.size() != 0) failures++;
    test_done();
  end
endmodule : arsr_regs_bench
